/* File: design/gst_map.vh */
// Purpose: register offsets, field positions and reset values of the
//          global system timer
// Assumes: byte addresses on an 8-bit APB address, one 32-bit word each
// Notes:   comparators, captures and scratch words are decoded by page
`ifndef GST_MAP_VH
`define GST_MAP_VH

// single registers
`define GST_CTRL_OFS      8'h00
`define GST_COUNT_OFS     8'h04
`define GST_CAPCFG_OFS    8'h08
`define GST_INTSTAT_OFS   8'h0C
`define GST_INTEN_OFS     8'h10
`define GST_INTCLR_OFS    8'h14

// banked registers: comparator page 0x20-0x3c, captures 0x40-0x4c,
// retained scratch words 0x50-0x58
`define GST_CMP_PAGE      3'b001
`define GST_CAP_PAGE      4'b0100
`define GST_SCR_PAGE      4'b0101
`define GST_NUM_CMP       8
`define GST_NUM_CAP       4
`define GST_NUM_SCR       3

// control fields: run bit and tick divider (tick every div+1 cycles)
`define GST_CTRL_RUN_BIT  0
`define GST_CTRL_DIV_LSB  8
`define GST_CTRL_DIV_MSB  15
`define GST_CTRL_MASK     32'h0000_FF01
`define GST_CTRL_RST      32'h0000_0001

// capture source select: two bits per capture, pin and pwm
`define GST_CAPCFG_PIN    0
`define GST_CAPCFG_PWM    1
`define GST_CAPCFG_RST    8'h01

// interrupt status layout
`define GST_ST_CMP_LSB    0
`define GST_ST_CAP_LSB    8
`define GST_ST_OVF_BIT    12
`define GST_ST_W          13

// timing: counting clock is pclk, 25 MHz, divided by the tick divider
`define GST_PCLK_MHZ      25

`endif

/* File: design/gst_sync2.v */
// Purpose: two-flop synchroniser for the asynchronous capture pins
// Assumes: inputs are slow levels or pulses of at least two pclk periods
// Notes:   only the second stage leaves this module
`timescale 1ns/10ps
module gst_sync2 #(
    parameter W = 4
) (
    // clock and reset
    input  wire         clk,
    input  wire         rst_n,
    // asynchronous in, synchronous out
    input  wire [W-1:0] async_in,
    output reg  [W-1:0] sync_out
);

    reg [W-1:0] meta_reg;

    // first stage feeds the second stage only
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= {W{1'b0}};
            sync_out <= {W{1'b0}};
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule

/* File: design/gst_cmp_unit.v */
// Purpose: one relative-offset comparator of the global system timer
// Assumes: count is the live global time counter on the same clock
// Notes:   a load arms the unit; one match pulse disarms it
`timescale 1ns/10ps
module gst_cmp_unit (
    // clock and cold reset
    input  wire        clk,
    input  wire        rst_n,
    // load of an offset and the live time
    input  wire        load,
    input  wire [31:0] offset,
    input  wire [31:0] count,
    // absolute match point and event
    output reg  [31:0] target,
    output reg         match
);

    reg armed_reg;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            target    <= 32'h0000_0000;
            armed_reg <= 1'b0;
            match     <= 1'b0;
        end else if (load) begin
            target    <= count + offset;
            armed_reg <= 1'b1;
            match     <= 1'b0;
        end else begin
            match <= armed_reg & (count == target);
            if (armed_reg && count == target) begin
                armed_reg <= 1'b0;
            end
        end
    end

endmodule

/* File: design/gst_top.v */
// Purpose: global system timer with eight relative comparators, four
//          capture timestamps, overflow event and retained scratch words
// Assumes: presetn is the cold power-on reset only; warm resets of the
//          rest of the chip must not reach this block
// Notes:   APB slave answers with no wait state; reads sample at setup
`timescale 1ns/10ps
`include "gst_map.vh"

// Function
// - one 32-bit counter, never altered by software
// - eight loadable 32-bit comparators with interrupts
// - comparator written as offset from current count
// - counter wrap signals an overflow event
// - four capture registers latch counter on trigger
// - capture trigger from pin, PWM or both
// - only cold power-on reset clears timer state
// - three retained 32-bit scratch registers
// - comparators A-H drive interrupts A-H
// - captures and overflow share ninth interrupt
module gst_top (
    // clock and cold power-on reset
    input  wire        pclk,
    input  wire        presetn,
    // apb slave
    input  wire [7:0]  paddr,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // capture triggers
    input  wire [3:0]  cap_pin,
    input  wire [3:0]  pwm_evt,
    // interrupt lines toward the processor interrupt controller
    output reg  [7:0]  irq_cmp,
    output reg         irq_share
);

    // byte-lane merge of write data into an old value
    function [31:0] lane_merge;
        input [31:0] old;
        input [31:0] wdat;
        input [3:0]  strb;
        integer k;
        begin
            lane_merge = old;
            for (k = 0; k < 4; k = k + 1) begin
                if (strb[k]) begin
                    lane_merge[8*k +: 8] = wdat[8*k +: 8];
                end
            end
        end
    endfunction

    // timer state
    reg  [31:0] count_reg;
    reg  [7:0]  div_cnt_reg;
    reg  [31:0] ctrl_reg;
    reg  [7:0]  capcfg_reg;
    reg  [12:0] stat_reg;
    reg  [12:0] stat_next;
    reg  [12:0] inten_reg;
    reg  [31:0] cap_reg [0:3];
    reg  [31:0] scr_reg [0:2];
    reg  [3:0]  pin_d_reg;
    wire [3:0]  pin_s;
    wire [31:0] cmp_target [0:7];
    wire [7:0]  cmp_evt;
    reg  [3:0]  cap_evt;
    reg  [31:0] rdata_c;
    reg         hit_c;
    integer     i;
    integer     ci;
    integer     si;

    // apb decode
    wire [7:0] addr     = {paddr[7:2], 2'b00};
    wire       setup    = psel & ~penable;
    wire       wr_en    = psel & penable & pready & pwrite;
    wire       is_cmp   = (addr[7:5] == `GST_CMP_PAGE);
    wire       is_cap   = (addr[7:4] == `GST_CAP_PAGE);
    wire       is_scr   = (addr[7:4] == `GST_SCR_PAGE) &&
                          (addr[3:2] != 2'b11);
    wire [7:0] cmp_ld   = {8{wr_en & is_cmp}} & (8'h01 << addr[4:2]);
    wire [31:0] cmp_ofs = lane_merge(32'h0000_0000, pwdata, pstrb);
    // enable write merged into the 13 defined bits only
    wire [31:0] inten_wr = lane_merge({19'h0_0000, inten_reg},
                                      pwdata, pstrb) & 32'h0000_1FFF;

    // tick divider output, the counting clock enable
    wire [7:0] div_max  = ctrl_reg[`GST_CTRL_DIV_MSB:`GST_CTRL_DIV_LSB];
    wire       tick     = ctrl_reg[`GST_CTRL_RUN_BIT] &
                          (div_cnt_reg == div_max);

    wire       ovf_evt  = tick & (&count_reg);

    // divider producing the one-cycle counting tick
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_reg <= 8'h00;
        end else if (!ctrl_reg[`GST_CTRL_RUN_BIT] || tick) begin
            div_cnt_reg <= 8'h00;
        end else begin
            div_cnt_reg <= div_cnt_reg + 8'h01;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= 32'h0000_0000;
        end else if (tick) begin
            count_reg <= count_reg + 32'h0000_0001;
        end
    end

    // comparator bank
    genvar g;
    generate
        for (g = 0; g < `GST_NUM_CMP; g = g + 1) begin : cmp
            gst_cmp_unit u_cmp (
                .clk    (pclk),
                .rst_n  (presetn),
                .load   (cmp_ld[g]),
                .offset (cmp_ofs),
                .count  (count_reg),
                .target (cmp_target[g]),
                .match  (cmp_evt[g])
            );
        end
    endgenerate

    // capture pins cross into pclk before edge detection
    gst_sync2 #(
        .W (4)
    ) u_sync (
        .clk      (pclk),
        .rst_n    (presetn),
        .async_in (cap_pin),
        .sync_out (pin_s)
    );

    // previous synchronised pin level for rising-edge detection
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_d_reg <= 4'h0;
        end else begin
            pin_d_reg <= pin_s;
        end
    end

    always @* begin
        for (i = 0; i < `GST_NUM_CAP; i = i + 1) begin
            cap_evt[i] =
                (capcfg_reg[2*i + `GST_CAPCFG_PIN] & pin_s[i] &
                 ~pin_d_reg[i]) |
                (capcfg_reg[2*i + `GST_CAPCFG_PWM] & pwm_evt[i]);
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (ci = 0; ci < `GST_NUM_CAP; ci = ci + 1) begin
                cap_reg[ci] <= 32'h0000_0000;
            end
        end else begin
            for (ci = 0; ci < `GST_NUM_CAP; ci = ci + 1) begin
                if (cap_evt[ci]) begin
                    cap_reg[ci] <= count_reg;
                end
            end
        end
    end

    // settings set to their reset values by cold reset only
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg   <= `GST_CTRL_RST;
            capcfg_reg <= `GST_CAPCFG_RST;
            inten_reg  <= 13'h0000;
        end else if (wr_en) begin
            case (addr)
                `GST_CTRL_OFS: begin
                    ctrl_reg <= lane_merge(ctrl_reg, pwdata, pstrb) &
                                `GST_CTRL_MASK;
                end
                `GST_CAPCFG_OFS: begin
                    if (pstrb[0]) begin
                        capcfg_reg <= pwdata[7:0];
                    end
                end
                `GST_INTEN_OFS: begin
                    inten_reg <= inten_wr[12:0];
                end
                default: begin
                    ctrl_reg <= ctrl_reg;
                end
            endcase
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (si = 0; si < `GST_NUM_SCR; si = si + 1) begin
                scr_reg[si] <= 32'h0000_0000;
            end
        end else if (wr_en && is_scr) begin
            scr_reg[addr[3:2]] <= lane_merge(scr_reg[addr[3:2]],
                                             pwdata, pstrb);
        end
    end

    // sticky flags, a set beats a same-cycle clear
    always @* begin
        stat_next = stat_reg;
        if (wr_en && addr == `GST_INTCLR_OFS) begin
            stat_next = stat_reg & ~pwdata[12:0];
        end
        stat_next = stat_next | {ovf_evt, cap_evt, cmp_evt};
    end

    // status register and registered interrupt lines
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_reg  <= 13'h0000;
            irq_cmp   <= 8'h00;
            irq_share <= 1'b0;
        end else begin
            stat_reg  <= stat_next;
            irq_cmp   <= stat_next[7:0] & inten_reg[7:0];
            irq_share <= |(stat_next[12:8] & inten_reg[12:8]);
        end
    end

    // read mux and address hit
    always @* begin
        rdata_c = 32'h0000_0000;
        hit_c   = 1'b1;
        if (is_cmp) begin
            rdata_c = cmp_target[addr[4:2]];
        end else if (is_cap) begin
            rdata_c = cap_reg[addr[3:2]];
        end else if (is_scr) begin
            rdata_c = scr_reg[addr[3:2]];
        end else begin
            case (addr)
                `GST_CTRL_OFS: begin
                    rdata_c = ctrl_reg;
                end
                `GST_COUNT_OFS: begin
                    rdata_c = count_reg;
                end
                `GST_CAPCFG_OFS: begin
                    rdata_c = {24'h00_0000, capcfg_reg};
                end
                `GST_INTSTAT_OFS: begin
                    rdata_c = {19'h0_0000, stat_reg};
                end
                `GST_INTEN_OFS: begin
                    rdata_c = {19'h0_0000, inten_reg};
                end
                `GST_INTCLR_OFS: begin
                    rdata_c = 32'h0000_0000;
                end
                default: begin
                    hit_c = 1'b0;
                end
            endcase
        end
    end

    // apb answer: prepared at setup, ready for the first access edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata  <= pwrite ? 32'h0000_0000 : rdata_c;
            pready  <= 1'b1;
            pslverr <= ~hit_c;
        end else begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

endmodule

/* File: verif/gst_top_monitor.sv */
// Purpose: port checks of the global system timer
// Assumes: slave answers in the first access cycle
// Notes:   bound to every gst_top instance
`timescale 1ns/10ps
module gst_top_monitor (
    // clock and cold reset
    input wire        pclk,
    input wire        presetn,
    // apb
    input wire [7:0]  paddr,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [31:0] pwdata,
    input wire [3:0]  pstrb,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    // triggers and interrupt lines
    input wire [3:0]  cap_pin,
    input wire [3:0]  pwm_evt,
    input wire [7:0]  irq_cmp,
    input wire        irq_share
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // setup cycle and a full-strobe enable write
    wire setup = psel && !penable;
    wire en_wr = psel && penable && pready && pwrite && paddr == 8'h10
                 && pstrb == 4'hf;
    a_ready_first: assert property (setup |=> pready)
        else $error("no ready in first access cycle");
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready stands too long");
    a_read_idle: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("read data outside access");
    a_unmap_err: assert property (setup && paddr[7:2] == 6'h17 |=> pslverr)
        else $error("unmapped access without error");
    a_err_mapped: assert property (pslverr |-> $past(paddr) >= 8'h5C
        || ($past(paddr) > 8'h17 && $past(paddr) < 8'h20))
        else $error("error on mapped address");
    a_clr_reads_zero: assert property (setup && !pwrite && paddr == 8'h14
        |=> prdata == 32'h0000_0000)
        else $error("clear register reads nonzero");
    a_enable_gate: assert property (en_wr && pwdata == 32'h0000_0000
        |-> ##2 irq_cmp == 8'h00 && !irq_share)
        else $error("interrupt with all enables off");
    a_cmp_gate: assert property (en_wr && pwdata[7:0] == 8'h00
        |-> ##2 irq_cmp == 8'h00)
        else $error("comparator line with its enable off");
    a_share_gate: assert property (en_wr && pwdata[12:8] == 5'h00
        |-> ##2 !irq_share)
        else $error("shared line with its enables off");
    // main scenarios reached
    cover property (pslverr);
    cover property ($rose(irq_share));
    cover property ($rose(irq_cmp[7]));
endmodule
bind gst_top gst_top_monitor mon_u (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cap_pin(cap_pin), .pwm_evt(pwm_evt),
    .irq_cmp(irq_cmp), .irq_share(irq_share));

/* File: verif/gst_far_model.sv */
// Purpose: trigger sources and interrupt controller stand-in
// Assumes: one pclk domain, pin levels change slowly
// Notes:   counts assertions of each of the nine interrupt lines
`timescale 1ns/10ps
module gst_far_model (
    // clock
    input wire       pclk,
    // bench commands
    input wire       fire_pwm,
    input wire       pin_lvl,
    // interrupt lines in, triggers out
    input wire [7:0] irq_cmp,
    input wire       irq_share,
    output reg [3:0] cap_pin,
    output reg [3:0] pwm_evt
);
    reg [8:0] irq_q;
    wire [8:0] irq_now = {irq_share, irq_cmp};
    int       rise_cnt [9];
    initial begin
        cap_pin = 4'h0;
        pwm_evt = 4'h0;
        irq_q = 9'h000;
        foreach (rise_cnt[k]) rise_cnt[k] = 0;
    end
    // one-cycle pwm event on all sources, pins follow the bench level
    always @(posedge pclk) begin
        pwm_evt <= fire_pwm ? 4'hf : 4'h0;
        cap_pin <= {4{pin_lvl}};
        irq_q <= irq_now;
        for (int k = 0; k < 9; k++) begin
            if (irq_now[k] === 1'b1 && irq_q[k] === 1'b0) begin
                rise_cnt[k]++;
            end
        end
    end
endmodule

/* File: verif/global_system_timer_tb_top.sv */
// Purpose: self-checking bench of the global system timer
// Assumes: apb answers are awaited, never counted on
// Notes:   expectations come from integer models kept here
`timescale 1ns/10ps
module global_system_timer_tb_top;
    reg          pclk = 1'b0;
    reg          presetn = 1'b0;
    reg  [7:0]   paddr = 8'h00;
    reg          psel = 1'b0;
    reg          penable = 1'b0;
    reg          pwrite = 1'b0;
    reg  [31:0]  pwdata = 32'h0000_0000;
    reg  [3:0]   pstrb = 4'hf;
    reg          fire_pwm = 1'b0;
    reg          pin_lvl = 1'b0;
    wire [31:0]  prdata;
    wire         pready;
    wire         pslverr;
    wire [3:0]   cap_pin;
    wire [3:0]   pwm_evt;
    wire [7:0]   irq_cmp;
    wire         irq_share;
    int          error_cnt = 0;
    int          total_checks = 0;
    int          cyc = 0;
    reg  [31:0]  rd;
    reg          er;
    int unsigned scr_m [3];
    int unsigned c0;
    int unsigned dv;
    int unsigned off;
    gst_top dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cap_pin(cap_pin), .pwm_evt(pwm_evt),
        .irq_cmp(irq_cmp), .irq_share(irq_share));
    gst_far_model far_u (.pclk(pclk), .fire_pwm(fire_pwm),
        .pin_lvl(pin_lvl), .irq_cmp(irq_cmp), .irq_share(irq_share),
        .cap_pin(cap_pin), .pwm_evt(pwm_evt));
    always #20 pclk = ~pclk;
    // hang guard
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            $display("ERROR %0t timeout", $time);
            conclude;
        end
    end
    task automatic conclude;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input [31:0] got, input [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one transfer; request held until ready is seen, psel left high
    task automatic apb(input w, input [7:0] a, input [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
    endtask
    task automatic idle;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    initial begin
        rd = $urandom(32'h2819);
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // reset values, then the unmapped word
        foreach (scr_m[k]) begin
            apb(0, 8'(8 * k), 0);
            chk(rd, k < 2);
        end
        apb(0, 8'h5C, 0);
        chk(rd, 0);
        chk(er, 1);
        // retained words hold random data
        foreach (scr_m[k]) begin
            scr_m[k] = $urandom;
            apb(1, 8'(80 + 4 * k), scr_m[k]);
            apb(0, 8'(80 + 4 * k), 0);
            chk(rd, scr_m[k]);
        end
        // tick divider: 4 ticks over 4*(div+1) cycles, counter read-only
        dv = $urandom_range(3);
        apb(1, 8'h00, (dv << 8) | 1);
        apb(0, 8'h04, 0);
        c0 = rd;
        apb(1, 8'h04, 0);
        repeat (2 * dv + 1) apb(0, 8'h04, 0);
        chk(rd, c0 + 4);
        apb(1, 8'h00, 0);
        apb(0, 8'h04, 0);
        c0 = rd;
        apb(0, 8'h04, 0);
        chk(rd, c0);
        apb(1, 8'h00, 1);
        // each comparator: offset from now, own line, sticky, cleared
        apb(1, 8'h10, 32'h0000_1FFF);
        for (int k = 0; k < 8; k++) begin
            off = $urandom_range(40, 3);
            apb(0, 8'h04, 0);
            c0 = rd;
            apb(1, 8'(32 + 4 * k), off);
            apb(0, 8'(32 + 4 * k), 0);
            chk(rd, c0 + 3 + off);
            idle;
            while (irq_cmp === 8'h00) @(posedge pclk);
            chk(irq_cmp, 1 << k);
            apb(0, 8'h0C, 0);
            chk(rd, 1 << k);
            apb(1, 8'h14, 32'h0000_1FFF);
            idle;
            chk(irq_cmp, 0);
        end
        // pending set while masked, line follows the enable
        apb(1, 8'h10, 32'h0000_1F00);
        apb(1, 8'h20, 2);
        idle;
        repeat (10) @(posedge pclk);
        chk(irq_cmp, 0);
        apb(0, 8'h0C, 0);
        chk(rd, 1);
        apb(1, 8'h10, 32'h0000_1FFF);
        idle;
        idle;
        chk(irq_cmp, 1);
        // pending kept, line drops once every enable is off
        apb(1, 8'h10, 32'h0000_00FF);
        apb(1, 8'h10, 32'h0000_0000);
        idle;
        idle;
        chk(irq_cmp, 0);
        apb(1, 8'h14, 32'h0000_1FFF);
        apb(1, 8'h10, 32'h0000_1FFF);
        // sources: c0 pin, c1 pwm, c2 both, c3 none
        apb(1, 8'h08, 32'h0000_0039);
        idle;
        fire_pwm <= 1'b1;
        @(posedge pclk);
        fire_pwm <= 1'b0;
        repeat (3) @(posedge pclk);
        chk(irq_share, 1);
        apb(0, 8'h0C, 0);
        chk(rd, 32'h0000_0600);
        apb(0, 8'h44, 0);
        c0 = rd;
        apb(0, 8'h48, 0);
        chk(rd, c0);
        apb(1, 8'h14, 32'h0000_1FFF);
        idle;
        chk(irq_share, 0);
        pin_lvl <= 1'b1;
        repeat (6) @(posedge pclk);
        apb(0, 8'h0C, 0);
        chk(rd, 32'h0000_0500);
        apb(0, 8'h40, 0);
        c0 = rd;
        apb(0, 8'h48, 0);
        chk(rd, c0);
        apb(0, 8'h4C, 0);
        chk(rd, 0);
        idle;
        // cold reset clears retained words
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, 8'h50, 0);
        chk(rd, 0);
        idle;
        for (int k = 0; k < 9; k++) chk(far_u.rise_cnt[k], 1 + (k % 8 == 0));
        conclude;
    end
endmodule
